// ===== logic/ufs_fifo_ctrl.sv
// fifo shadow control: alias registers, trigger decode, halt and interrupts
// Functional notes
// R1 - fifo enable register writes only fifo control bit 0
// R2 - fifo enable one enables both fifos, zero disables them
// R3 - clearing enable after set resets both fifo controllers
// R4 - receive trigger register writes only fifo control bits 7:6
// R5 - receive code 00 is one character, 11 is two below full
// R6 - data available interrupt when receive fill reaches trigger level
// R7 - in dma mode one, receive request low at trigger level
// R8 - transmit trigger register writes only fifo control bits 5:4
// R9 - transmit code 00 is empty, 01 is two characters left
// R10 - holding empty interrupt at threshold only while threshold mode active
// R11 - halt bit with fifos enabled stops transmission
// R12 - halt bit ignored while fifos are disabled
// R13 - receive 01/10 quarter/half full; transmit 10/11 quarter/half
// R14 - reserved bits read zero, writes ignored
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "ufs_regs.svh"
module ufs_fifo_ctrl
   import ufs_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // register port
   input wire logic [`UFS_ADDR_W-1:0] ADDR,
   input wire logic [`UFS_DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [`UFS_DATA_W-1:0] RDATA,
   // fifo state from the serial core
   input wire logic [`UFS_CNT_W-1:0] RX_FILL,
   input wire logic [`UFS_CNT_W-1:0] TX_FILL,
   input wire logic DMA_MODE,
   input wire logic TRANSMIT_HOLDING_EMPTY_MODE,
   // control toward the serial core
   output logic FIFO_ENABLE,
   output logic FIFO_RESET,
   output logic TX_HALT,
   output logic RX_DMA_REQ_N,
   output logic RX_DATA_AVAIL,
   output logic TX_HOLDING_EMPTY,
   // interrupt
   output logic IRQ
);
   logic fifo_en_reg;
   logic [1:0] rx_trig_reg;
   logic [1:0] tx_trig_reg;
   logic halt_reg;
   logic [`UFS_INT_W-1:0] int_stat_reg;
   logic [`UFS_INT_W-1:0] int_mask_reg;
   logic [`UFS_INT_W-1:0] int_evt;
   logic rx_level;
   logic tx_level;
   logic rx_level_reg;
   logic tx_level_reg;
   logic transmit_holding_empty_mode_s;
   logic dma_mode_s;
   logic [7:0] fcr_view;
   // level and threshold signals
   logic [`UFS_CNT_W-1:0] rx_thresh;
   logic [`UFS_CNT_W-1:0] tx_thresh;
   logic rx_gated;
   logic tx_gated;
   logic [`UFS_DATA_W-1:0] rd_next;

   // address decode
   logic sel_sfe;
   logic sel_srt;
   logic sel_stet;
   logic sel_htx;
   logic sel_cpr;
   logic sel_ist;
   logic sel_imsk;
   logic sel_fcr;

   // write strobes per register
   logic wr_sfe;
   logic wr_srt;
   logic wr_stet;
   logic wr_htx;
   logic wr_ist;
   logic wr_imsk;
   logic wr_fcr;
   logic en_fall;

   // address compare used by every decode
   function automatic logic hit(input logic [`UFS_ADDR_W-1:0] a,
                                input logic [`UFS_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // receive fill threshold for each trigger code
   function automatic logic [`UFS_CNT_W-1:0] rx_threshold(input logic [1:0] code);
      unique case (ufs_rx_trig_t'(code))
         UFS_RX_ONE: begin
            rx_threshold = `UFS_CNT_W'(`UFS_RX_ONE_LVL); // R5
         end
         UFS_RX_QUARTER: begin
            rx_threshold = `UFS_CNT_W'(`UFS_FIFO_DEPTH / 4); // R13
         end
         UFS_RX_HALF: begin
            rx_threshold = `UFS_CNT_W'(`UFS_FIFO_DEPTH / 2); // R13
         end
         UFS_RX_TWO_LESS: begin
            rx_threshold = `UFS_CNT_W'(`UFS_FIFO_DEPTH - `UFS_RX_GAP); // R5
         end
      endcase
   endfunction

   // transmit fill threshold; code 00 means fully drained
   function automatic logic [`UFS_CNT_W-1:0] tx_threshold(input logic [1:0] code);
      unique case (ufs_tx_trig_t'(code))
         UFS_TX_EMPTY: begin
            tx_threshold = `UFS_CNT_W'(`UFS_TX_EMPTY_LVL); // R9
         end
         UFS_TX_TWO: begin
            tx_threshold = `UFS_CNT_W'(`UFS_TX_TWO_LVL); // R9
         end
         UFS_TX_QUARTER: begin
            tx_threshold = `UFS_CNT_W'(`UFS_FIFO_DEPTH / 4); // R13
         end
         UFS_TX_HALF: begin
            tx_threshold = `UFS_CNT_W'(`UFS_FIFO_DEPTH / 2); // R13
         end
      endcase
   endfunction

   // mode levels come from another block; synchronise them
   ufs_pin_sync u_transmit_holding_empty_sync (
      .clk(CLOCK),
      .rst_n(RST_N),
      .pin_in(TRANSMIT_HOLDING_EMPTY_MODE),
      .pin_out(transmit_holding_empty_mode_s)
   );

   ufs_pin_sync u_dma_sync (
      .clk(CLOCK),
      .rst_n(RST_N),
      .pin_in(DMA_MODE),
      .pin_out(dma_mode_s)
   );

   assign sel_sfe = hit(ADDR, `UFS_OFS_SFE);
   assign sel_srt = hit(ADDR, `UFS_OFS_SRT);
   assign sel_stet = hit(ADDR, `UFS_OFS_STET);
   assign sel_htx = hit(ADDR, `UFS_OFS_HTX);
   assign sel_cpr = hit(ADDR, `UFS_OFS_CPR);
   assign sel_ist = hit(ADDR, `UFS_OFS_IST);
   assign sel_imsk = hit(ADDR, `UFS_OFS_IMSK);
   assign sel_fcr = hit(ADDR, `UFS_OFS_FCR);

   assign wr_sfe = WR && sel_sfe;
   assign wr_srt = WR && sel_srt;
   assign wr_stet = WR && sel_stet;
   assign wr_htx = WR && sel_htx;
   assign wr_ist = WR && sel_ist;
   assign wr_imsk = WR && sel_imsk;
   assign wr_fcr = WR && sel_fcr;

   // an enable write that clears a set enable
   assign en_fall = (wr_sfe || wr_fcr) && fifo_en_reg &&
                    !WDATA[`UFS_FCR_EN_BIT];

   // shadow enable alias and the full control view
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         fifo_en_reg <= 1'b0;
      end else if (wr_sfe) begin
         fifo_en_reg <= WDATA[`UFS_ALIAS_BIT]; // R1 R14
      end else if (wr_fcr) begin
         fifo_en_reg <= WDATA[`UFS_FCR_EN_BIT];
      end
   end

   assign FIFO_ENABLE = fifo_en_reg; // R2

   // one-cycle controller reset of both fifos
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         FIFO_RESET <= 1'b0;
      end else begin
         FIFO_RESET <= en_fall; // R3
      end
   end

   // receive trigger alias
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         rx_trig_reg <= 2'b00;
      end else if (wr_srt) begin
         rx_trig_reg <= WDATA[`UFS_ALIAS_HI:`UFS_ALIAS_LO]; // R4 R14
      end else if (wr_fcr) begin
         rx_trig_reg <= WDATA[`UFS_FCR_RX_HI:`UFS_FCR_RX_LO];
      end
   end

   // transmit empty trigger alias
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         tx_trig_reg <= 2'b00;
      end else if (wr_stet) begin
         tx_trig_reg <= WDATA[`UFS_ALIAS_HI:`UFS_ALIAS_LO]; // R8 R14
      end else if (wr_fcr) begin
         tx_trig_reg <= WDATA[`UFS_FCR_TX_HI:`UFS_FCR_TX_LO];
      end
   end

   // transmit halt test bit
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         halt_reg <= 1'b0;
      end else if (wr_htx) begin
         halt_reg <= WDATA[`UFS_ALIAS_BIT];
      end
   end

   // halt has no effect while the fifos are disabled
   assign TX_HALT = halt_reg && fifo_en_reg; // R11 R12

   // control view: rx trigger, tx trigger, dma mode, enable
   assign fcr_view = {rx_trig_reg, tx_trig_reg, dma_mode_s, 2'b00, fifo_en_reg};

   // trigger level compare
   assign rx_thresh = rx_threshold(rx_trig_reg);
   assign tx_thresh = tx_threshold(tx_trig_reg);

   assign rx_level = (RX_FILL >= rx_thresh); // R6
   assign tx_level = (TX_FILL <= tx_thresh); // R9
   assign rx_gated = rx_level && fifo_en_reg; // R6
   assign tx_gated = tx_level && fifo_en_reg && transmit_holding_empty_mode_s; // R10

   // previous levels, for edge detection
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         rx_level_reg <= 1'b0;
      end else begin
         rx_level_reg <= rx_gated;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         tx_level_reg <= 1'b0;
      end else begin
         tx_level_reg <= tx_gated;
      end
   end

   // registered level outputs
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         RX_DATA_AVAIL <= 1'b0;
      end else begin
         RX_DATA_AVAIL <= rx_gated; // R6
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         TX_HOLDING_EMPTY <= 1'b0;
      end else begin
         TX_HOLDING_EMPTY <= tx_gated; // R10
      end
   end

   // request is active low
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         RX_DMA_REQ_N <= 1'b1;
      end else begin
         RX_DMA_REQ_N <= !(dma_mode_s && rx_gated); // R7
      end
   end

   // rising edges of the levels and the fifo reset pulse are the interrupt events
   assign int_evt[`UFS_INT_RDA] = rx_gated && !rx_level_reg;
   assign int_evt[`UFS_INT_TRANSMIT_HOLDING_EMPTY] = tx_gated && !tx_level_reg;
   assign int_evt[`UFS_INT_FRST] = FIFO_RESET;

   // set wins over write-one-to-clear
   generate
      for (genvar b = 0; b < `UFS_INT_W; b++) begin : g_stat
         always_ff @(posedge CLOCK) begin
            if (!RST_N) begin
               int_stat_reg[b] <= 1'b0;
            end else if (int_evt[b]) begin
               int_stat_reg[b] <= 1'b1;
            end else if (wr_ist && WDATA[b]) begin
               int_stat_reg[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // interrupt mask, same layout as status
   generate
      for (genvar b = 0; b < `UFS_INT_W; b++) begin : g_mask
         always_ff @(posedge CLOCK) begin
            if (!RST_N) begin
               int_mask_reg[b] <= 1'b0;
            end else if (wr_imsk) begin
               int_mask_reg[b] <= WDATA[b];
            end
         end
      end
   endgenerate

   assign IRQ = |(int_stat_reg & int_mask_reg);

   // read mux; idle cycles and unmapped addresses give zero
   always_comb begin
      rd_next = '0;
      if (RD) begin
         if (sel_sfe) begin
            rd_next[`UFS_ALIAS_BIT] = fifo_en_reg; // R14
         end else if (sel_srt) begin
            rd_next[`UFS_ALIAS_HI:`UFS_ALIAS_LO] = rx_trig_reg;
         end else if (sel_stet) begin
            rd_next[`UFS_ALIAS_HI:`UFS_ALIAS_LO] = tx_trig_reg;
         end else if (sel_htx) begin
            rd_next[`UFS_ALIAS_BIT] = halt_reg;
         end else if (sel_cpr) begin
            rd_next = `UFS_CPR_VAL;
         end else if (sel_ist) begin
            rd_next[`UFS_INT_W-1:0] = int_stat_reg;
         end else if (sel_imsk) begin
            rd_next[`UFS_INT_W-1:0] = int_mask_reg;
         end else if (sel_fcr) begin
            rd_next[`UFS_FCR_RX_HI:`UFS_FCR_EN_BIT] = fcr_view;
         end
      end
   end

   // read data stand for one cycle only
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         RDATA <= '0;
      end else begin
         RDATA <= rd_next;
      end
   end
endmodule

// ===== logic/ufs_regs.svh
// register map and field constants for the fifo shadow control block
`ifndef UFS_REGS_SVH
`define UFS_REGS_SVH
`define UFS_ADDR_W 32
`define UFS_DATA_W 16
`define UFS_OFS_SFE 32'h50001198
`define UFS_OFS_SRT 32'h5000119c
`define UFS_OFS_STET 32'h500011a0
`define UFS_OFS_HTX 32'h500011a4
`define UFS_OFS_CPR 32'h500011f4
`define UFS_OFS_IST 32'h500011e0
`define UFS_OFS_IMSK 32'h500011e4
`define UFS_OFS_FCR 32'h500011e8
`define UFS_CPR_VAL 16'h0000
`define UFS_FIFO_DEPTH 16
`define UFS_CNT_W 5
`define UFS_INT_W 3
`define UFS_INT_RDA 0
`define UFS_INT_TRANSMIT_HOLDING_EMPTY 1
`define UFS_INT_FRST 2
`define UFS_ALIAS_BIT 0
`define UFS_ALIAS_LO 0
`define UFS_ALIAS_HI 1
`define UFS_FCR_EN_BIT 0
`define UFS_FCR_TX_LO 4
`define UFS_FCR_TX_HI 5
`define UFS_FCR_RX_LO 6
`define UFS_FCR_RX_HI 7
`define UFS_RX_ONE_LVL 1
`define UFS_RX_GAP 2
`define UFS_TX_EMPTY_LVL 0
`define UFS_TX_TWO_LVL 2
`endif

// ===== logic/ufs_pkg.sv
// types shared by the fifo shadow control block
package ufs_pkg;
   typedef enum logic [1:0] {
      UFS_RX_ONE = 2'b00,
      UFS_RX_QUARTER = 2'b01,
      UFS_RX_HALF = 2'b10,
      UFS_RX_TWO_LESS = 2'b11
   } ufs_rx_trig_t;
   typedef enum logic [1:0] {
      UFS_TX_EMPTY = 2'b00,
      UFS_TX_TWO = 2'b01,
      UFS_TX_QUARTER = 2'b10,
      UFS_TX_HALF = 2'b11
   } ufs_tx_trig_t;
endpackage

// ===== logic/ufs_pin_sync.sv
// three-stage pin synchroniser with second/third agreement
`timescale 1ns/1ps
module ufs_pin_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic pin_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_out <= 1'b0;
      end else if (s2_reg == s3_reg) begin
         pin_out <= s3_reg;
      end
   end
endmodule

// ===== tb/ufs_core_model.sv
// serial core stand-in: fill counters of both fifos
`timescale 1ns/1ps
module ufs_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control from the block
   input wire logic fifo_reset,
   input wire logic tx_halt,
   // bench requests
   input wire logic rx_push,
   input wire logic tx_push,
   // fill levels
   output logic [4:0] rx_fill,
   output logic [4:0] tx_fill
);
   always_ff @(posedge clk) begin
      if (!rst_n || fifo_reset) begin
         rx_fill <= 5'h00;
         tx_fill <= 5'h00;
      end else begin
         if (rx_push && rx_fill < 5'h10)
            rx_fill <= rx_fill + 5'h01;
         if (tx_push && tx_fill < 5'h10)
            tx_fill <= tx_fill + 5'h01;
         else if (!tx_halt && tx_fill != 5'h00)
            tx_fill <= tx_fill - 5'h01;
      end
   end
endmodule

// ===== tb/ufs_fifo_ctrl_props.sv
// port assertions of the fifo shadow control block
`timescale 1ns/1ps
`include "ufs_regs.svh"
module ufs_fifo_ctrl_props (
   input wire logic CLOCK, RST_N, WR, RD,
   input wire logic [`UFS_ADDR_W-1:0] ADDR,
   input wire logic [`UFS_DATA_W-1:0] WDATA, RDATA,
   input wire logic [`UFS_CNT_W-1:0] RX_FILL, TX_FILL,
   input wire logic FIFO_ENABLE, FIFO_RESET, TX_HALT,
   input wire logic RX_DMA_REQ_N, RX_DATA_AVAIL, TX_HOLDING_EMPTY
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   wire sfe_wr = WR && ADDR == `UFS_OFS_SFE;
   a_enable_alias: assert property (sfe_wr |=> FIFO_ENABLE == $past(WDATA[0]))
      else $error("enable does not follow write");
   a_reset_pulse: assert property (sfe_wr && FIFO_ENABLE && !WDATA[0] |=>
      FIFO_RESET ##1 !FIFO_RESET) else $error("no fifo reset pulse");
   a_reset_cause: assert property (FIFO_RESET |-> !FIFO_ENABLE && $past(FIFO_ENABLE))
      else $error("fifo reset without disable");
   a_halt_gated: assert property (TX_HALT |-> FIFO_ENABLE)
      else $error("halt while disabled");
   a_read_idle: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data outside read");
   a_read_upper: assert property (RD |=> RDATA[15:8] == 8'h00)
      else $error("upper read bits set");
   a_read_trig: assert property (RD && ADDR == `UFS_OFS_SRT |=> RDATA[15:2] == 14'h0000)
      else $error("trigger reserved bits set");
   a_rx_empty: assert property (RX_DATA_AVAIL |-> $past(RX_FILL) != 5'h00)
      else $error("data available while empty");
   a_rx_high: assert property ($past(RX_FILL) >= 5'h0e && FIFO_ENABLE &&
      $past(FIFO_ENABLE) |-> RX_DATA_AVAIL) else $error("data available missing");
   a_dma_empty: assert property (!RX_DMA_REQ_N |-> $past(RX_FILL) != 5'h00)
      else $error("dma request while empty");
   a_transmit_holding_empty_level: assert property (TX_HOLDING_EMPTY |-> $past(TX_FILL) <= 5'h08)
      else $error("holding empty above threshold");
   c_reset: cover property (FIFO_RESET);
   c_halt: cover property (TX_HALT ##1 TX_HOLDING_EMPTY);
   c_dma: cover property (!RX_DMA_REQ_N && RX_DATA_AVAIL);
endmodule
bind ufs_fifo_ctrl ufs_fifo_ctrl_props u_props (.CLOCK(CLOCK), .RST_N(RST_N), .WR(WR),
   .RD(RD), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .RX_FILL(RX_FILL), .TX_FILL(TX_FILL),
   .FIFO_ENABLE(FIFO_ENABLE), .FIFO_RESET(FIFO_RESET), .TX_HALT(TX_HALT),
   .RX_DMA_REQ_N(RX_DMA_REQ_N), .RX_DATA_AVAIL(RX_DATA_AVAIL),
   .TX_HOLDING_EMPTY(TX_HOLDING_EMPTY));

// ===== tb/uart_fifo_shadow_control_test.sv
// self-checking bench for the fifo shadow control block
`timescale 1ns/1ps
`include "ufs_regs.svh"
module uart_fifo_shadow_control_test;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, dma = 1'b0, thm = 1'b0;
   logic rxp = 1'b0, txp = 1'b0, fen, frst, halt, dreq_n, avail, transmit_holding_empty, irq;
   logic [31:0] addr = 32'h00000000;
   logic [15:0] wdata = 16'h0000, rdata;
   logic [4:0] rxf, txf;
   int mismatches = 0, checked = 0;
   always #50 clk = ~clk;
   ufs_fifo_ctrl u_dut (.CLOCK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .RX_FILL(rxf), .TX_FILL(txf), .DMA_MODE(dma), .TRANSMIT_HOLDING_EMPTY_MODE(thm),
      .FIFO_ENABLE(fen), .FIFO_RESET(frst), .TX_HALT(halt), .RX_DMA_REQ_N(dreq_n),
      .RX_DATA_AVAIL(avail), .TX_HOLDING_EMPTY(transmit_holding_empty), .IRQ(irq));
   ufs_core_model u_core (.clk(clk), .rst_n(rst_n), .fifo_reset(frst), .tx_halt(halt),
      .rx_push(rxp), .tx_push(txp), .rx_fill(rxf), .tx_fill(txf));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wr_reg(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [31:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task push(input logic rx, input int n);
      if (n > 0) begin
         @(posedge clk);
         rxp <= rx;
         txp <= !rx;
         repeat (n) @(posedge clk);
         rxp <= 1'b0;
         txp <= 1'b0;
      end
   endtask
   task t_regs;
      logic [31:0] map [6] = '{`UFS_OFS_SFE, `UFS_OFS_SRT, `UFS_OFS_STET, `UFS_OFS_HTX,
         `UFS_OFS_CPR, 32'h500011f0};
      logic [15:0] back [6] = '{16'h0001, 16'h0003, 16'h0003, 16'h0001, 16'h0000, 16'h0000};
      foreach (map[i]) rd_reg(map[i], 16'h0000);
      foreach (map[i]) wr_reg(map[i], 16'hffff);
      foreach (map[i]) rd_reg(map[i], back[i]);
      rd_reg(`UFS_OFS_FCR, 16'h00f1);
      wr_reg(`UFS_OFS_SRT, 16'h0000);
      rd_reg(`UFS_OFS_FCR, 16'h0031);
      wr_reg(`UFS_OFS_STET, 16'h0001);
      rd_reg(`UFS_OFS_FCR, 16'h0011);
      wr_reg(`UFS_OFS_SFE, 16'h0000);
      #1 chk(frst, 1'b1);
      chk(fen, 16'h0000);
      rd_reg(`UFS_OFS_FCR, 16'h0010);
      chk(halt, 1'b0);
   endtask
   task t_rx;
      int thr [4] = '{1, 4, 8, 14};
      dma <= 1'b1;
      foreach (thr[i]) begin
         wr_reg(`UFS_OFS_SFE, 16'h0001);
         wr_reg(`UFS_OFS_SRT, 16'(i));
         push(1'b1, thr[i] - 1);
         tick(2);
         chk(avail, 1'b0);
         chk(dreq_n, 1'b1);
         push(1'b1, 1);
         tick(2);
         chk(avail, 1'b1);
         chk(dreq_n, 1'b0);
         wr_reg(`UFS_OFS_SFE, 16'h0000);
         #1 chk(frst, 1'b1);
      end
   endtask
   task t_tx;
      int thr [4] = '{0, 2, 4, 8};
      thm <= 1'b1;
      foreach (thr[i]) begin
         wr_reg(`UFS_OFS_SFE, 16'h0001);
         wr_reg(`UFS_OFS_HTX, 16'h0001);
         wr_reg(`UFS_OFS_STET, 16'(i));
         push(1'b0, thr[i]);
         tick(6);
         chk(transmit_holding_empty, 1'b1);
         push(1'b0, 1);
         tick(2);
         chk(transmit_holding_empty, 1'b0);
         chk(txf, 16'(thr[i] + 1));
         wr_reg(`UFS_OFS_SFE, 16'h0000);
      end
      push(1'b0, 3);
      tick(6);
      chk(txf, 16'h0000);
      wr_reg(`UFS_OFS_SFE, 16'h0001);
      thm <= 1'b0;
      tick(6);
      chk(transmit_holding_empty, 1'b0);
   endtask
   task t_irq;
      wr_reg(`UFS_OFS_IST, 16'h0007);
      wr_reg(`UFS_OFS_SRT, 16'h0000);
      wr_reg(`UFS_OFS_IMSK, 16'h0001);
      #1 chk(irq, 1'b0);
      push(1'b1, 1);
      tick(2);
      chk(irq, 1'b1);
      rd_reg(`UFS_OFS_IST, 16'h0001);
      wr_reg(`UFS_OFS_IMSK, 16'h0000);
      #1 chk(irq, 1'b0);
      wr_reg(`UFS_OFS_IMSK, 16'h0001);
      wr_reg(`UFS_OFS_IST, 16'h0001);
      #1 chk(irq, 1'b0);
   endtask
   task summarize;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_rx;
      t_tx;
      t_irq;
      summarize;
   end
   initial begin
      #2000000;
      mismatches++;
      summarize;
   end
endmodule
